// *** rtl/lti_regs.sv ***
// gain and line termination control registers of a phone line interface
// wishbone slave at clk; hook state and on-hook request from line logic
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "lti_defs.svh"
module lti_regs
   import lti_pkg::*;
#(
   parameter int SAMPLE_DIV = `LTI_SAMPLE_DIV,
   parameter int FAST_SAMPLES = `LTI_FAST_SAMPLES,
   parameter int SLOW_SAMPLES = `LTI_SLOW_SAMPLES
) (
   // system
   input wire logic clk,
   input wire logic sys_rst,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // line state
   input wire logic offHook,
   input wire logic onHookStart,
   // transmit and receive path
   output logic txMute,
   output logic [3:0] txAttenDb,
   output logic rxMute,
   output logic [3:0] rxGainDb,
   output logic [5:0] monAttenTenthDb,
   // termination and ringer
   output logic dcTermOff,
   output logic dcImp800,
   output logic dctPinReduced,
   output logic squelchEn,
   output logic acTermComplex,
   output lti_dct_mode_type dcTermMode,
   output logic ringerSynth,
   output logic ringThreshHigh,
   // on-hook timing
   output logic onHookSlow,
   output logic onHookBusy,
   output logic onHookDone
);
   lti_reg_if rif ();
   logic [7:0] gain_r, gain_nxt, term_r, term_nxt;
   logic [7:0] out_gain_r, out_term_r;
   logic offHook_r, dual;

   lti_wb_slave u_bus (
      .clk(clk),
      .sys_rst(sys_rst),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .rif(rif.bus)
   );

   // 3-step gain code in dB, top bit saturating to the fifth step
   function automatic logic [3:0] step3db(input logic [2:0] c);
      logic [3:0] r;
      r = 4'h0;
      case (c)
         3'b000: r = 4'h0;
         3'b001: r = 4'h3;
         3'b010: r = 4'h6;
         3'b011: r = 4'h9;
         default: r = 4'hc;
      endcase
      return r;
   endfunction

   // register bank
   always_comb begin
      gain_nxt = gain_r;
      term_nxt = term_r;
      if (rif.wrEn && rif.idx == `LTI_IDX_GAIN) begin
         gain_nxt = rif.wdata;
      end
      if (rif.wrEn && rif.idx == `LTI_IDX_TERM) begin
         term_nxt = rif.wdata & `LTI_TERM_WMASK;
      end
   end

   always_comb begin
      case (rif.idx)
         `LTI_IDX_GAIN: rif.rdata = gain_r;
         `LTI_IDX_TERM: rif.rdata = term_r;
         default: rif.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gain_r <= `LTI_RST_GAIN;
         term_r <= `LTI_RST_TERM;
      end else begin
         gain_r <= gain_nxt;
         term_r <= term_nxt;
      end
   end

   // register and hook-state copies, one edge behind; data outputs are decoded from these flops
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_gain_r <= `LTI_RST_GAIN;
         out_term_r <= `LTI_RST_TERM;
         offHook_r <= 1'b0;
      end else begin
         out_gain_r <= gain_r;
         out_term_r <= term_r;
         offHook_r <= offHook;
      end
   end

   assign dual = out_term_r[`LTI_B_DUAL];
   assign txMute = out_gain_r[`LTI_B_TXMUTE];
   assign txAttenDb = step3db(
      out_gain_r[`LTI_B_TXATT_HI:`LTI_B_TXATT_LO]);
   assign rxMute = out_gain_r[`LTI_B_RXMUTE];
   // 1xx on the regular path is undefined; held at the top step
   assign rxGainDb = out_gain_r[`LTI_B_RXSEL_HI] ? 4'h9 :
      step3db(out_gain_r[`LTI_B_RXSEL_HI:`LTI_B_RXSEL_LO]);

   always_comb begin
      case (out_gain_r[`LTI_B_RXSEL_HI:`LTI_B_RXSEL_LO])
         3'b000: monAttenTenthDb = 6'h00;
         3'b001: monAttenTenthDb = 6'h0a;
         3'b010: monAttenTenthDb = 6'h16;
         3'b011: monAttenTenthDb = 6'h23;
         default: monAttenTenthDb = 6'h32;
      endcase
   end

   // bit 7 meaning follows the hook state
   assign dcTermOff = dual && offHook_r;
   assign dcImp800 = dual && offHook_r;
   assign dctPinReduced = dual && offHook_r;
   assign squelchEn = dual && !offHook_r;
   assign onHookSlow = out_term_r[`LTI_B_OHS];
   assign acTermComplex = out_term_r[`LTI_B_ACT];
   assign dcTermMode = lti_dct_mode_type'(
      out_term_r[`LTI_B_DCT_HI:`LTI_B_DCT_LO]);
   assign ringerSynth = out_term_r[`LTI_B_RZ];
   assign ringThreshHigh = out_term_r[`LTI_B_RT];

   // speed is sampled at start; later writes do not stretch a release
   lti_onhook_timer #(
      .SAMPLE_DIV(SAMPLE_DIV),
      .FAST_SAMPLES(FAST_SAMPLES),
      .SLOW_SAMPLES(SLOW_SAMPLES)
   ) u_hook (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(onHookStart),
      .slow(onHookSlow),
      .busy(onHookBusy),
      .done(onHookDone)
   );

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_wrGain;
      wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
         && wb_adr_i[7:2] == `LTI_IDX_GAIN;
   endsequence

   sequence s_rdTerm;
      wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
         && wb_adr_i[7:2] == `LTI_IDX_TERM;
   endsequence

   property p_txMute;
      s_wrGain ##0 wb_dat_i[7] |-> ##2 txMute;
   endproperty
   a_txMute: assert property (p_txMute)
      else $error("transmit mute not applied");

   property p_txAtten;
      s_wrGain ##0 wb_dat_i[6:4] == 3'b101 |-> ##2 txAttenDb == 4'hc;
   endproperty
   a_txAtten: assert property (p_txAtten)
      else $error("transmit attenuation not 12 dB");

   property p_rxMute;
      gain_r[3] == 1'b0 |=> !rxMute;
   endproperty
   a_rxMute: assert property (p_rxMute)
      else $error("receive muted while bit clear");

   property p_rxGain;
      gain_r[2:0] == 3'b011 |=> rxGainDb == 4'h9 && monAttenTenthDb == 6'h23;
   endproperty
   a_rxGain: assert property (p_rxGain)
      else $error("receive gain code 011 wrong");

   property p_monAtten;
      gain_r[2] |=> monAttenTenthDb == 6'h32;
   endproperty
   a_monAtten: assert property (p_monAtten)
      else $error("monitor attenuation not 5 dB");

   property p_offTerm;
      term_r[7] && offHook |=> dcTermOff && dcImp800 && !squelchEn;
   endproperty
   a_offTerm: assert property (p_offTerm)
      else $error("dc termination not turned off");

   property p_squelch;
      term_r[7] && !offHook |=> squelchEn && !dcTermOff;
   endproperty
   a_squelch: assert property (p_squelch)
      else $error("squelch not enabled on-hook");

   property p_termFields;
      1'b1 |=> acTermComplex == $past(term_r[5])
         && dcTermMode == $past(term_r[3:2])
         && ringerSynth == $past(term_r[1])
         && ringThreshHigh == $past(term_r[0])
         && onHookSlow == $past(term_r[6]);
   endproperty
   a_termFields: assert property (p_termFields)
      else $error("termination field outputs lag register");

   property p_rsvdZero;
      s_rdTerm |=> wb_ack_o && wb_dat_o[4] == 1'b0
         && wb_dat_o[7:5] == $past(term_r[7:5]);
   endproperty
   a_rsvdZero: assert property (p_rsvdZero)
      else $error("reserved bit reads nonzero");

   // span checker; counts busy cycles, no repetition long enough to unroll
   localparam int FAST_MIN = (FAST_SAMPLES - 1) * SAMPLE_DIV + 1;
   localparam int FAST_MAX = FAST_SAMPLES * SAMPLE_DIV;
   localparam int SLOW_MIN = (SLOW_SAMPLES - 1) * SAMPLE_DIV + 1;
   localparam int SLOW_MAX = SLOW_SAMPLES * SAMPLE_DIV;
   localparam int HW = $clog2(SLOW_MAX + 2);
   logic [HW-1:0] hookCnt_r, hookCnt_nxt;
   logic hookSlow_r, hookSlow_nxt;
   logic hookTake;

   assign hookTake = onHookStart && !onHookBusy && !onHookDone;

   always_comb begin
      hookCnt_nxt = onHookBusy ? hookCnt_r + HW'(1) : '0;
      hookSlow_nxt = hookTake ? onHookSlow : hookSlow_r;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hookCnt_r <= '0;
         hookSlow_r <= 1'b0;
      end else begin
         hookCnt_r <= hookCnt_nxt;
         hookSlow_r <= hookSlow_nxt;
      end
   end

   property p_hookStart;
      hookTake |=> onHookBusy;
   endproperty
   a_hookStart: assert property (p_hookStart)
      else $error("off-hook counter did not start");

   property p_hookSpan;
      onHookDone |-> (hookSlow_r ?
         hookCnt_r >= HW'(SLOW_MIN) && hookCnt_r <= HW'(SLOW_MAX) :
         hookCnt_r >= HW'(FAST_MIN) && hookCnt_r <= HW'(FAST_MAX));
   endproperty
   a_hookSpan: assert property (p_hookSpan)
      else $error("off-hook counter span wrong");

   property p_offClear;
      !term_r[7] |=> !dcTermOff && !dcImp800 && !dctPinReduced
         && !squelchEn;
   endproperty
   a_offClear: assert property (p_offClear)
      else $error("termination off or squelch while bit clear");

   sequence s_wrTerm;
      wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
         && wb_adr_i[7:2] == `LTI_IDX_TERM;
   endsequence

   property p_termWrite;
      s_wrTerm |=> term_r == ($past(wb_dat_i[7:0]) & `LTI_TERM_WMASK);
   endproperty
   a_termWrite: assert property (p_termWrite)
      else $error("termination write not stored");
endmodule
`default_nettype wire

// *** rtl/lti_defs.svh ***
// register map, field positions, reset values and timing counts
// included by the line interface control modules
`ifndef LTI_DEFS_SVH
`define LTI_DEFS_SVH
`define LTI_IDX_W 6
`define LTI_IDX_GAIN 6'h0f
`define LTI_IDX_TERM 6'h10
`define LTI_RST_GAIN 8'h00
`define LTI_RST_TERM 8'h00
`define LTI_B_TXMUTE 7
`define LTI_B_TXATT_HI 6
`define LTI_B_TXATT_LO 4
`define LTI_B_RXMUTE 3
`define LTI_B_RXSEL_HI 2
`define LTI_B_RXSEL_LO 0
`define LTI_B_DUAL 7
`define LTI_B_OHS 6
`define LTI_B_ACT 5
`define LTI_B_RSVD 4
`define LTI_B_DCT_HI 3
`define LTI_B_DCT_LO 2
`define LTI_B_RZ 1
`define LTI_B_RT 0
`define LTI_TERM_WMASK 8'hef
`define LTI_FAST_SAMPLES 1024
`define LTI_SLOW_SAMPLES 4096
`define LTI_SAMPLE_DIV 1250
`endif

// *** rtl/lti_pkg.sv ***
// types shared by the line interface control modules
// no assumptions beyond a SystemVerilog compiler
package lti_pkg;
   typedef enum logic [2:0] {
      HOOK_IDLE = 3'b001,
      HOOK_COUNT = 3'b010,
      HOOK_DONE = 3'b100
   } lti_hook_state_type;
   typedef enum logic [1:0] {
      DCT_LOWV = 2'b00,
      DCT_JAPAN = 2'b01,
      DCT_FCC = 2'b10,
      DCT_CTR21 = 2'b11
   } lti_dct_mode_type;
endpackage

// *** rtl/lti_reg_if.sv ***
// register access carrier between bus slave and register bank
// one clock domain; bus slave drives the request fields, register bank drives rdata
`timescale 1ns/1ps
`default_nettype none
`include "lti_defs.svh"
interface lti_reg_if;
   logic wrEn;
   logic [`LTI_IDX_W-1:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport bus (output wrEn, output idx, output wdata, input rdata);
   modport regs (input wrEn, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// *** rtl/lti_wb_slave.sv ***
// classic wishbone slave, one wait state, 8-bit registers in low lane
// master holds request until ack; ack is never given two cycles running
`timescale 1ns/1ps
`default_nettype none
`include "lti_defs.svh"
module lti_wb_slave
   import lti_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic sys_rst,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // register side
   lti_reg_if.bus rif
);
   logic ack_r, ack_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic req;

   assign req = wb_cyc_i && wb_stb_i;
   assign rif.idx = wb_adr_i[7:2];
   assign rif.wdata = wb_dat_i[7:0];
   // write lands on the edge where the master sees ack
   assign rif.wrEn = req && wb_we_i && ack_r && wb_sel_i[0];
   assign wb_ack_o = ack_r;
   assign wb_dat_o = {24'h00_0000, rd_r};

   always_comb begin
      ack_nxt = req && !ack_r;
      rd_nxt = rd_r;
      if (req && !ack_r) begin
         rd_nxt = wb_we_i ? 8'h00 : rif.rdata;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
         rd_r <= 8'h00;
      end else begin
         ack_r <= ack_nxt;
         rd_r <= rd_nxt;
      end
   end
endmodule
`default_nettype wire

// *** rtl/lti_onhook_timer.sv ***
// off-hook counter run when the line is released
// counts sample periods derived from clk by a divider
`timescale 1ns/1ps
`default_nettype none
`include "lti_defs.svh"
module lti_onhook_timer
   import lti_pkg::*;
#(
   parameter int SAMPLE_DIV = `LTI_SAMPLE_DIV,
   parameter int FAST_SAMPLES = `LTI_FAST_SAMPLES,
   parameter int SLOW_SAMPLES = `LTI_SLOW_SAMPLES
) (
   // system
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic start,
   input wire logic slow,
   // status
   output logic busy,
   output logic done
);
   localparam int DW = $clog2(SAMPLE_DIV + 1);
   localparam int CW = $clog2(SLOW_SAMPLES + 1);
   lti_hook_state_type st_r, st_nxt;
   logic [DW-1:0] div_r, div_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt, tgt_r, tgt_nxt;
   logic tick;

   // sample-rate enable; free running so ticks stay on the sample grid
   assign tick = (div_r == DW'(SAMPLE_DIV - 1));
   assign busy = (st_r == HOOK_COUNT);
   assign done = (st_r == HOOK_DONE);

   always_comb begin
      div_nxt = tick ? '0 : div_r + DW'(1);
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      tgt_nxt = tgt_r;
      case (st_r)
         HOOK_IDLE: begin
            if (start) begin
               st_nxt = HOOK_COUNT;
               cnt_nxt = '0;
               tgt_nxt = slow ? CW'(SLOW_SAMPLES) : CW'(FAST_SAMPLES);
            end
         end
         HOOK_COUNT: begin
            if (tick) begin
               cnt_nxt = cnt_r + CW'(1);
               if (cnt_r == tgt_r - CW'(1)) begin
                  st_nxt = HOOK_DONE;
               end
            end
         end
         HOOK_DONE: st_nxt = HOOK_IDLE;
         default: st_nxt = HOOK_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= HOOK_IDLE;
         div_r <= '0;
         cnt_r <= '0;
         tgt_r <= '0;
      end else begin
         st_r <= st_nxt;
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         tgt_r <= tgt_nxt;
      end
   end
endmodule
`default_nettype wire

// *** sim/lti_regs_tb.sv ***
// self-checking bench for the gain and line termination registers
// assumes lti_regs alone, one 10 MHz clock, bench drives every port
`timescale 1ns/1ps
`default_nettype none
module lti_regs_tb
   import lti_pkg::*;
;
   // short counts keep the on-hook runs brief
   localparam int DIV = 2;
   localparam int NFAST = 4;
   localparam int NSLOW = 8;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dati = 32'h0000_0000;
   logic [31:0] dato;
   logic ack;
   logic offHook = 1'b0;
   logic onHookStart = 1'b0;
   logic txMute;
   logic rxMute;
   logic [3:0] txAttenDb;
   logic [3:0] rxGainDb;
   logic [5:0] monAttenTenthDb;
   logic dcTermOff;
   logic dcImp800;
   logic dctPinReduced;
   logic squelchEn;
   logic acTermComplex;
   lti_dct_mode_type dcTermMode;
   logic ringerSynth;
   logic ringThreshHigh;
   logic onHookSlow;
   logic onHookBusy;
   logic onHookDone;
   logic [31:0] rd;
   int fails = 0;
   int tests_run = 0;

   always #50 clk = ~clk;

   lti_regs #(.SAMPLE_DIV(DIV), .FAST_SAMPLES(NFAST),
      .SLOW_SAMPLES(NSLOW)) i_dut (
      .clk(clk), .sys_rst(sys_rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
      .offHook(offHook), .onHookStart(onHookStart),
      .txMute(txMute), .txAttenDb(txAttenDb), .rxMute(rxMute),
      .rxGainDb(rxGainDb), .monAttenTenthDb(monAttenTenthDb),
      .dcTermOff(dcTermOff), .dcImp800(dcImp800),
      .dctPinReduced(dctPinReduced), .squelchEn(squelchEn),
      .acTermComplex(acTermComplex), .dcTermMode(dcTermMode),
      .ringerSynth(ringerSynth), .ringThreshHigh(ringThreshHigh),
      .onHookSlow(onHookSlow), .onHookBusy(onHookBusy),
      .onHookDone(onHookDone));

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // request held until ack is sampled, then idle for one cycle
   task automatic wbXfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dati <= d;
      sel <= s;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1)
         fails++;
      rd = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wbXfer(1'b1, a, {24'h00_0000, d}, 4'h1);
   endtask

   task automatic rdReg(input logic [7:0] a);
      wbXfer(1'b0, a, 32'h0000_0000, 4'h1);
   endtask

   // decoded outputs lag the register by one edge; read before the
   // last edge's updates land, so drives stay on the edge
   task automatic settle();
      repeat (2) @(posedge clk);
   endtask

   function automatic logic [31:0] monExp(input logic [2:0] c);
      if (c[2])
         return 50;
      case (c[1:0])
         2'b00: return 0;
         2'b01: return 10;
         2'b10: return 22;
         default: return 35;
      endcase
   endfunction

   task automatic hookRun(input logic s, input int n_samp);
      int n;
      wr(8'h40, {1'b0, s, 6'h00});
      onHookStart <= 1'b1;
      @(posedge clk);
      onHookStart <= 1'b0;
      check("onHookSlow", onHookSlow, s);
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (n == 1)
            check("onHookBusy run", onHookBusy, 1);
      end while (onHookDone !== 1'b1 && n < 200);
      // n is the busy cycles plus the edge that shows done
      check("onhook span", n - 1 >= (n_samp - 1) * DIV + 1
         && n - 1 <= n_samp * DIV, 1);
      @(posedge clk);
      check("onHookDone", onHookDone, 0);
      check("onHookBusy", onHookBusy, 0);
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      results();
   end

   initial begin
      logic [2:0] c;
      logic [1:0] m;
      logic [7:0] v;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rdReg(8'h3c);
      check("gain reset", rd, 0);
      rdReg(8'h40);
      check("term reset", rd, 0);
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         v = {c[0], c, ~c[0], c};
         wr(8'h3c, v);
         settle();
         check("txMute", txMute, c[0]);
         // legacy attenuation bit lives outside this block, never set
         check("txAttenDb", txAttenDb, c[2] ? 12 : c * 3);
         check("rxMute", rxMute, !c[0]);
         check("rxGainDb", rxGainDb, c[2] ? 9 : c * 3);
         check("monAtten", monAttenTenthDb, monExp(c));
         rdReg(8'h3c);
         check("gain read", rd, v);
      end
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         v = {1'b0, m[0], m[1], 1'b1, m, m[1] ^ m[0], ~m[0]};
         wr(8'h40, v);
         settle();
         check("dcTermMode", dcTermMode, m);
         check("acTerm", acTermComplex, m[1]);
         check("ringer", ringerSynth, m[1] ^ m[0]);
         check("ringThresh", ringThreshHigh, !m[0]);
         rdReg(8'h40);
         check("term read", rd, v & 8'hef);
      end
      wr(8'h40, 8'h80);
      for (int h = 0; h < 2; h++) begin
         offHook <= h[0];
         settle();
         check("dcTermOff", dcTermOff, h[0]);
         check("dcImp800", dcImp800, h[0]);
         check("dctPin", dctPinReduced, h[0]);
         check("squelchEn", squelchEn, !h[0]);
      end
      wr(8'h40, 8'h00);
      settle();
      check("dcTermOff clr", dcTermOff, 0);
      wr(8'h44, 8'hff);
      rdReg(8'h44);
      check("unmapped read", rd, 0);
      wbXfer(1'b1, 8'h3c, 32'h0000_00a5, 4'he);
      rdReg(8'h3c);
      check("sel0 low write", rd, 8'hf7);
      hookRun(1'b0, NFAST);
      hookRun(1'b1, NSLOW);
      results();
   end
endmodule
`default_nettype wire
